// [hw/eapc_defines.vh]
// Constants for the external and pin-change interrupt unit.
`ifndef EAPC_DEFINES_VH
`define EAPC_DEFINES_VH

// ==========================================================================
// Register indices; the bus byte address is four times the index.
// ==========================================================================
`define EAPC_IDX_EXT_ENABLE_MASK 8'h1d
`define EAPC_IDX_GROUP_CONTROL 8'h68
`define EAPC_IDX_GROUP0_MASK 8'h6b
`define EAPC_IDX_GROUP1_MASK 8'h6c
`define EAPC_IDX_GROUP2_MASK 8'h6d
`define EAPC_IDX_GROUP3_MASK 8'h73
`define EAPC_IDX_SENSE_CONTROL 8'h74
`define EAPC_IDX_EXT_FLAGS 8'h75
`define EAPC_IDX_GROUP_FLAGS 8'h76

// ==========================================================================
// Field layout and reset values.
// ==========================================================================
`define EAPC_NUM_DED 3
`define EAPC_NUM_GRP 4
`define EAPC_GRP_WIDTH 8
`define EAPC_SENSE_MSB 5
`define EAPC_RESET_BYTE 8'h00

// ==========================================================================
// Sense selector encodings.
// ==========================================================================
`define EAPC_SENSE_LOW 2'h0
`define EAPC_SENSE_ANY 2'h1
`define EAPC_SENSE_FALL 2'h2
`define EAPC_SENSE_RISE 2'h3

// ==========================================================================
// Bus answers.
// ==========================================================================
`define EAPC_RESP_OKAY 2'h0
`define EAPC_RESP_SLVERR 2'h2

`endif

// [hw/eapc_ext_pin_irq.v]
// External pin and pin-change interrupt unit with an AXI4-Lite register slave.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "eapc_defines.vh"

module eapc_ext_pin_irq #(
  parameter ADDR_W = 10
) (
  input wire clk,
  input wire reset_n,
  // Software register bus.
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Pins as seen at the pad input, whatever the pin direction is.
  input wire [2:0] dedicated_irq_pins,
  input wire [31:0] change_detect_inputs,
  // Core side.
  input wire globalIrqEnable,
  input wire sleepActive,
  input wire [2:0] dedicatedServiced,
  input wire [3:0] groupServiced,
  output wire [2:0] dedicatedIrqRequest,
  output wire [3:0] changeGroupRequest,
  output wire asyncWake
);

  // ========================================================================
  // Register state.
  // ========================================================================
  reg [2:0] enableMask_q; // Dedicated pin enables.
  reg [5:0] senseCtl_q; // Two sense bits per dedicated pin.
  reg [3:0] groupCtl_q; // Group enables.
  reg [31:0] groupMask_q; // Per-line masks, group n in bits 8n+7:8n.
  reg [2:0] dedFlag_q; // Dedicated pin flags.
  reg [3:0] grpFlag_q; // Group flags.

  // ========================================================================
  // Input conditioning and synchronisers.
  // ========================================================================
  // A dedicated pin whose input buffer is off during sleep reads as low.
  // That forced level can itself look like a change and set a flag.
  wire [2:0] dedGated;
  assign dedGated = dedicated_irq_pins & ~({3{sleepActive}} & ~enableMask_q);

  wire [34:0] rawIn;
  assign rawIn = {dedGated, change_detect_inputs};

  reg [34:0] sync1_q; // First stage, read only by the second.
  reg [34:0] sync2_q; // Settled copy in the clock domain.
  reg [34:0] prev_q; // Previous settled copy, for change detection.

  // Two flops ahead of any logic; then one more stage to compare against.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= 35'h0;
      sync2_q <= 35'h0;
      prev_q <= 35'h0;
    end else begin
      sync1_q <= rawIn;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // ========================================================================
  // Sense decoding, shared by the flag logic and the wake path.
  // ========================================================================
  // Returns true when the sense mode sees an event between two samples.
  function senseHit;
    input [1:0] mode;
    input oldLvl;
    input newLvl;
    begin
      case (mode)
        `EAPC_SENSE_LOW: senseHit = ~newLvl;
        `EAPC_SENSE_ANY: senseHit = oldLvl ^ newLvl;
        `EAPC_SENSE_FALL: senseHit = oldLvl & ~newLvl;
        `EAPC_SENSE_RISE: senseHit = ~oldLvl & newLvl;
        default: senseHit = 1'b0;
      endcase
    end
  endfunction

  // ========================================================================
  // Dedicated pins: events, wake terms and requests.
  // ========================================================================
  wire [2:0] dedEvent; // Synchronised edge events in edge modes.
  wire [2:0] dedLevel; // Sense set to low level.
  wire [2:0] dedWake; // Unclocked wake terms.
  genvar gi;
  generate
    for (gi = 0; gi < `EAPC_NUM_DED; gi = gi + 1) begin : gDed
      assign dedLevel[gi] = (senseCtl_q[2*gi+1:2*gi] == `EAPC_SENSE_LOW);
      assign dedEvent[gi] = ~dedLevel[gi] &
        senseHit(senseCtl_q[2*gi+1:2*gi], prev_q[32+gi], sync2_q[32+gi]);
      // The raw pin is compared with the last clocked sample; with the clock
      // stopped that sample holds, so any qualifying edge shows at once.
      assign dedWake[gi] = enableMask_q[gi] &
        senseHit(senseCtl_q[2*gi+1:2*gi], sync2_q[32+gi], dedGated[gi]);
      // Level mode asks for as long as the settled pin is low; a level that
      // vanishes before the clock is back never produces a request.
      assign dedicatedIrqRequest[gi] = globalIrqEnable & enableMask_q[gi] &
        (dedLevel[gi] ? ~sync2_q[32+gi] : dedFlag_q[gi]);
    end
  endgenerate

  // ========================================================================
  // Pin-change groups: events, wake terms and requests.
  // ========================================================================
  wire [3:0] grpEvent; // Synchronised masked toggles per group.
  wire [3:0] grpWake; // Unclocked masked toggles per group.
  generate
    for (gi = 0; gi < `EAPC_NUM_GRP; gi = gi + 1) begin : gGrp
      assign grpEvent[gi] = |((prev_q[8*gi+7:8*gi] ^ sync2_q[8*gi+7:8*gi]) &
        groupMask_q[8*gi+7:8*gi]);
      assign grpWake[gi] = groupCtl_q[gi] &
        (|((change_detect_inputs[8*gi+7:8*gi] ^ sync2_q[8*gi+7:8*gi]) &
        groupMask_q[8*gi+7:8*gi]));
      assign changeGroupRequest[gi] = globalIrqEnable & groupCtl_q[gi] &
        grpFlag_q[gi];
    end
  endgenerate

  // The wake line is purely combinational so it works with no clock at all.
  // It may glitch on a narrow pulse; the power manager must tolerate that.
  assign asyncWake = (|dedWake) | (|grpWake);

  // ========================================================================
  // Bus slave: write side.
  // ========================================================================
  reg awHeld_q; // Write address taken, waiting for data.
  reg [ADDR_W-1:0] awAddr_q; // Held write address.
  reg wHeld_q; // Write data taken, waiting for address.
  reg [7:0] wData_q; // Held low byte of write data.
  reg wStrb_q; // Held lane-zero strobe.

  // Each channel is taken once and held until the response leaves.
  assign s_axi_awready = ~awHeld_q & ~s_axi_bvalid;
  assign s_axi_wready = ~wHeld_q & ~s_axi_bvalid;

  wire awFire;
  wire wFire;
  assign awFire = s_axi_awvalid & s_axi_awready;
  assign wFire = s_axi_wvalid & s_axi_wready;

  wire haveAw;
  wire haveW;
  wire [ADDR_W-1:0] curAw;
  wire [7:0] curWd;
  wire curStrb;
  assign haveAw = awHeld_q | awFire;
  assign haveW = wHeld_q | wFire;
  assign curAw = awHeld_q ? awAddr_q : s_axi_awaddr;
  assign curWd = wHeld_q ? wData_q : s_axi_wdata[7:0];
  assign curStrb = wHeld_q ? wStrb_q : s_axi_wstrb[0];

  // The write is committed in the cycle both halves are present.
  wire doWrite;
  assign doWrite = haveAw & haveW & ~s_axi_bvalid;

  // Register decode, used by both the write and the read side.
  function [3:0] decodeIdx;
    input [ADDR_W-1:0] addr;
    begin
      case (addr[ADDR_W-1:2])
        `EAPC_IDX_EXT_ENABLE_MASK: decodeIdx = 4'h1;
        `EAPC_IDX_GROUP_CONTROL: decodeIdx = 4'h2;
        `EAPC_IDX_GROUP0_MASK: decodeIdx = 4'h3;
        `EAPC_IDX_GROUP1_MASK: decodeIdx = 4'h4;
        `EAPC_IDX_GROUP2_MASK: decodeIdx = 4'h5;
        `EAPC_IDX_GROUP3_MASK: decodeIdx = 4'h6;
        `EAPC_IDX_SENSE_CONTROL: decodeIdx = 4'h7;
        `EAPC_IDX_EXT_FLAGS: decodeIdx = 4'h8;
        `EAPC_IDX_GROUP_FLAGS: decodeIdx = 4'h9;
        default: decodeIdx = 4'h0;
      endcase
    end
  endfunction

  wire [3:0] wrSel;
  wire wrEn;
  assign wrSel = decodeIdx(curAw);
  assign wrEn = doWrite & curStrb; // Only lane zero carries register bits.

  // Channel holding and the write response.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      awHeld_q <= 1'b0;
      awAddr_q <= {ADDR_W{1'b0}};
      wHeld_q <= 1'b0;
      wData_q <= 8'h00;
      wStrb_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `EAPC_RESP_OKAY;
    end else begin
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wrSel == 4'h0) ? `EAPC_RESP_SLVERR : `EAPC_RESP_OKAY;
      end else begin
        if (awFire) begin
          awHeld_q <= 1'b1;
          awAddr_q <= s_axi_awaddr;
        end
        if (wFire) begin
          wHeld_q <= 1'b1;
          wData_q <= s_axi_wdata[7:0];
          wStrb_q <= s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // ========================================================================
  // Control registers.
  // ========================================================================
  // Software-owned fields; unwritable bits simply are not stored.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      enableMask_q <= 3'h0;
      senseCtl_q <= 6'h0;
      groupCtl_q <= 4'h0;
      groupMask_q <= 32'h0;
    end else if (wrEn) begin
      case (wrSel)
        4'h1: enableMask_q <= curWd[2:0];
        4'h2: groupCtl_q <= curWd[3:0];
        4'h3: groupMask_q[7:0] <= curWd;
        4'h4: groupMask_q[15:8] <= curWd;
        4'h5: groupMask_q[23:16] <= curWd;
        4'h6: groupMask_q[31:24] <= curWd;
        4'h7: senseCtl_q <= curWd[`EAPC_SENSE_MSB:0];
        default: enableMask_q <= enableMask_q;
      endcase
    end
  end

  // ========================================================================
  // Flags.
  // ========================================================================
  wire [2:0] dedClr;
  wire [3:0] grpClr;
  assign dedClr = dedicatedServiced |
    ((wrEn && wrSel == 4'h8) ? curWd[2:0] : 3'h0);
  assign grpClr = groupServiced |
    ((wrEn && wrSel == 4'h9) ? curWd[3:0] : 4'h0);

  // A new event in the clearing cycle wins, so no event is lost.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dedFlag_q <= 3'h0;
      grpFlag_q <= 4'h0;
    end else begin
      dedFlag_q <= ((dedFlag_q & ~dedClr) | dedEvent) & ~dedLevel;
      grpFlag_q <= (grpFlag_q & ~grpClr) | grpEvent;
    end
  end

  // ========================================================================
  // Bus slave: read side.
  // ========================================================================
  assign s_axi_arready = ~s_axi_rvalid;

  reg [7:0] rdByte; // Selected register value.
  wire [3:0] rdSel;
  assign rdSel = decodeIdx(s_axi_araddr);

  // Read multiplexer; bits above each register's width read as zero.
  always @* begin
    case (rdSel)
      4'h1: rdByte = {5'h0, enableMask_q};
      4'h2: rdByte = {4'h0, groupCtl_q};
      4'h3: rdByte = groupMask_q[7:0];
      4'h4: rdByte = groupMask_q[15:8];
      4'h5: rdByte = groupMask_q[23:16];
      4'h6: rdByte = groupMask_q[31:24];
      4'h7: rdByte = {2'h0, senseCtl_q};
      4'h8: rdByte = {5'h0, dedFlag_q};
      4'h9: rdByte = {4'h0, grpFlag_q};
      default: rdByte = `EAPC_RESET_BYTE;
    endcase
  end

  // Read data is captured when the address is taken and held until taken.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `EAPC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h0, rdByte};
      s_axi_rresp <= (rdSel == 4'h0) ? `EAPC_RESP_SLVERR : `EAPC_RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// [dv/eapc_ext_pin_irq_assertions.sv]
// Checker for the bus handshakes and request gating of the pin interrupt unit.
`timescale 1ns/10ps
module eapc_ext_pin_irq_assertions (
  input wire clk,
  input wire reset_n,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire globalIrqEnable,
  input wire [2:0] dedicatedIrqRequest,
  input wire [3:0] changeGroupRequest
);
  // ==========================================================================
  // Handshake steps
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Both write halves taken at one edge commits the write.
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Answer is up and both write channels are closed meanwhile.
  sequence wr_answer;
    s_axi_bvalid && !s_axi_awready && !s_axi_wready;
  endsequence
  // ==========================================================================
  // Properties
  // ==========================================================================
  a_write_answer: assert property (wr_taken |=> wr_answer) else $error("no write answer");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
    && !s_axi_arready) else $error("no read answer");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_data_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read answer dropped");
  a_resp_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer stuck");
  a_byte_only: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_gie_dedicated: assert property (!globalIrqEnable |-> dedicatedIrqRequest == 3'h0)
    else $error("dedicated request without global enable");
  a_gie_group: assert property (!globalIrqEnable |-> changeGroupRequest == 4'h0)
    else $error("group request without global enable");
endmodule

bind eapc_ext_pin_irq eapc_ext_pin_irq_assertions eapc_ext_pin_irq_assertions_i (
  .clk, .reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .globalIrqEnable, .dedicatedIrqRequest,
  .changeGroupRequest
);

// [dv/eapc_core_model.sv]
// Model of the pads and of the core that accepts interrupts.
`timescale 1ns/10ps
module eapc_core_model (
  input wire clk,
  input wire reset_n,
  input wire ackEnable,
  input wire [2:0] dedLevel,
  input wire [31:0] chgLevel,
  input wire [2:0] dedicatedIrqRequest,
  input wire [3:0] changeGroupRequest,
  output wire [2:0] dedicated_irq_pins,
  output wire [31:0] change_detect_inputs,
  output reg [2:0] dedicatedServiced,
  output reg [3:0] groupServiced
);
  // Pads hold each commanded level until the bench changes it.
  assign dedicated_irq_pins = dedLevel;
  assign change_detect_inputs = chgLevel;
  // The core enters a handler with a one-cycle pulse; the gap lets the flag drop.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dedicatedServiced <= 3'h0;
      groupServiced <= 4'h0;
    end else begin
      dedicatedServiced <= ackEnable ? (dedicatedIrqRequest & ~dedicatedServiced) : 3'h0;
      groupServiced <= ackEnable ? (changeGroupRequest & ~groupServiced) : 4'h0;
    end
  end
endmodule

// [dv/eapc_ext_pin_irq_bench.sv]
// Self-checking bench for the external pin and pin-change interrupt unit.
`timescale 1ns/10ps
`include "eapc_defines.vh"
module eapc_ext_pin_irq_bench;
  // ==========================================================================
  // Signals
  // ==========================================================================
  reg clk = 1'b0;
  reg reset_n = 1'b0;
  reg [9:0] s_axi_awaddr = 10'h0, s_axi_araddr = 10'h0;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'h1; // Only the low byte carries register data.
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  reg globalIrqEnable = 1'b0, sleepActive = 1'b0, ackEnable = 1'b0;
  reg [2:0] dedLevel = 3'h0;
  reg [31:0] chgLevel = 32'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, asyncWake;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, change_detect_inputs;
  wire [2:0] dedicated_irq_pins, dedicatedServiced, dedicatedIrqRequest;
  wire [3:0] groupServiced, changeGroupRequest;
  int miscompares = 0;
  int numChecks = 0;
  // Mask register index of each change group, group 0 first.
  logic [7:0] maskIdx [4] = '{`EAPC_IDX_GROUP0_MASK, `EAPC_IDX_GROUP1_MASK,
    `EAPC_IDX_GROUP2_MASK, `EAPC_IDX_GROUP3_MASK};
  // Free-running 20 MHz clock.
  initial begin
    forever #25 clk = ~clk;
  end
  eapc_ext_pin_irq #(.ADDR_W(10)) eapc_ext_pin_irq_i (
    .clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .dedicated_irq_pins, .change_detect_inputs, .globalIrqEnable, .sleepActive,
    .dedicatedServiced, .groupServiced, .dedicatedIrqRequest, .changeGroupRequest, .asyncWake);
  eapc_core_model eapc_core_model_i (.clk, .reset_n, .ackEnable, .dedLevel, .chgLevel,
    .dedicatedIrqRequest, .changeGroupRequest, .dedicated_irq_pins, .change_detect_inputs,
    .dedicatedServiced, .groupServiced);
  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Bus write: both halves offered together, each released when taken.
  task wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] resp);
    bit aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge clk);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, resp);
  endtask
  // Bus read with the expected byte and answer code.
  task rd(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] resp);
    @(posedge clk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge clk);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, exp);
    chk(s_axi_rresp, resp);
  endtask
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task check_registers;
    int i;
    for (i = 0; i < 4; i++) rd(maskIdx[i], 32'h0, 2'h0);
    rd(`EAPC_IDX_EXT_FLAGS, 32'h0, 2'h0);
    wr(`EAPC_IDX_SENSE_CONTROL, 8'hff, 2'h0);
    rd(`EAPC_IDX_SENSE_CONTROL, 32'h3f, 2'h0);
    wr(`EAPC_IDX_GROUP1_MASK, 8'ha5, 2'h0);
    rd(`EAPC_IDX_GROUP1_MASK, 32'ha5, 2'h0);
    wr(8'h00, 8'hff, `EAPC_RESP_SLVERR);
    rd(8'h00, 32'h0, `EAPC_RESP_SLVERR);
  endtask
  // Each group sees only its masked line; the unmasked neighbour stays silent.
  task check_groups;
    int g;
    globalIrqEnable <= 1'b1;
    wr(`EAPC_IDX_GROUP_CONTROL, 8'h0f, 2'h0);
    for (g = 0; g < 4; g++) begin
      wr(maskIdx[g], 8'h80, 2'h0);
      chgLevel[8 * g] <= 1'b1;
      repeat (4) @(posedge clk);
      chk(changeGroupRequest, 32'h0);
      chgLevel[8 * g + 7] <= 1'b1;
      #1;
      chk(asyncWake, 32'h1);
      repeat (4) @(posedge clk);
      chk(changeGroupRequest, 32'(1 << g));
      rd(`EAPC_IDX_GROUP_FLAGS, 32'(1 << g), 2'h0);
      wr(`EAPC_IDX_GROUP_FLAGS, 8'(1 << g), 2'h0);
      chk(changeGroupRequest, 32'h0);
    end
    globalIrqEnable <= 1'b0;
    chgLevel[31] <= 1'b0;
    repeat (4) @(posedge clk);
    globalIrqEnable <= 1'b1;
    @(posedge clk);
    chk(changeGroupRequest, 32'h8);
    // Let the core take the group vector; entering the handler must drop the flag.
    ackEnable <= 1'b1;
    repeat (3) @(posedge clk);
    ackEnable <= 1'b0;
    chk(changeGroupRequest, 32'h0);
    wr(`EAPC_IDX_GROUP_FLAGS, 8'h08, 2'h0);
  endtask
  // Every edge code on every pin, with the safe reconfiguration order.
  task check_edges;
    int p, m;
    for (p = 0; p < 3; p++) begin
      for (m = 1; m < 4; m++) begin
        wr(`EAPC_IDX_EXT_ENABLE_MASK, 8'h00, 2'h0);
        wr(`EAPC_IDX_SENSE_CONTROL, 8'(m << (2 * p)), 2'h0);
        wr(`EAPC_IDX_EXT_FLAGS, 8'h07, 2'h0);
        wr(`EAPC_IDX_EXT_ENABLE_MASK, 8'(1 << p), 2'h0);
        dedLevel[p] <= 1'b1;
        repeat (4) @(posedge clk);
        chk(dedicatedIrqRequest, (m != 2) ? 32'(1 << p) : 32'h0);
        wr(`EAPC_IDX_EXT_FLAGS, 8'h07, 2'h0);
        dedLevel[p] <= 1'b0;
        repeat (4) @(posedge clk);
        rd(`EAPC_IDX_EXT_FLAGS, (m != 3) ? 32'(1 << p) : 32'h0, 2'h0);
      end
    end
    wr(`EAPC_IDX_EXT_FLAGS, 8'h07, 2'h0);
    ackEnable <= 1'b1;
    dedLevel[2] <= 1'b1;
    repeat (6) @(posedge clk);
    rd(`EAPC_IDX_EXT_FLAGS, 32'h0, 2'h0);
    ackEnable <= 1'b0;
  endtask
  // Level sensing requests for as long as the pin is low and keeps the flag clear.
  task check_level;
    wr(`EAPC_IDX_EXT_ENABLE_MASK, 8'h00, 2'h0);
    wr(`EAPC_IDX_SENSE_CONTROL, 8'h00, 2'h0);
    wr(`EAPC_IDX_EXT_ENABLE_MASK, 8'h04, 2'h0);
    dedLevel[2] <= 1'b0;
    repeat (24) @(posedge clk);
    chk(dedicatedIrqRequest, 32'h4);
    rd(`EAPC_IDX_EXT_FLAGS, 32'h0, 2'h0);
    globalIrqEnable <= 1'b0;
    repeat (2) @(posedge clk);
    chk(dedicatedIrqRequest, 32'h0);
    globalIrqEnable <= 1'b1;
    dedLevel[2] <= 1'b1;
    repeat (4) @(posedge clk);
    chk(dedicatedIrqRequest, 32'h0);
  endtask
  // Sleep with the pin disabled forces a falling level; then the unclocked wake term.
  task check_sleep;
    wr(`EAPC_IDX_EXT_ENABLE_MASK, 8'h00, 2'h0);
    wr(`EAPC_IDX_SENSE_CONTROL, 8'h20, 2'h0);
    wr(`EAPC_IDX_EXT_FLAGS, 8'h07, 2'h0);
    sleepActive <= 1'b1;
    repeat (4) @(posedge clk);
    rd(`EAPC_IDX_EXT_FLAGS, 32'h4, 2'h0);
    sleepActive <= 1'b0;
    wr(`EAPC_IDX_EXT_FLAGS, 8'h07, 2'h0);
    wr(`EAPC_IDX_EXT_ENABLE_MASK, 8'h04, 2'h0);
    chk(asyncWake, 32'h0);
    dedLevel[2] <= 1'b0;
    #1;
    chk(asyncWake, 32'h1);
    repeat (4) @(posedge clk);
    chk(dedicatedIrqRequest, 32'h4);
    wr(`EAPC_IDX_EXT_FLAGS, 8'h07, 2'h0);
  endtask
  // ==========================================================================
  // Sequence, watchdog and verdict
  // ==========================================================================
  task end_of_test;
    $display("checks %0d miscompares %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    check_registers();
    check_groups();
    check_edges();
    check_level();
    check_sleep();
    end_of_test();
  end
  // The whole run needs a few hundred cycles; a hang ends it here.
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_of_test();
  end
endmodule
